// file: sram_bus_map.svh
`ifndef SRAM_BUS_MAP_SVH
`define SRAM_BUS_MAP_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define STATUS_OFFSET 12'h000
`define CTRL_OFFSET 12'h004
`define BEATS_OFFSET 12'h008

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define STATUS_OP_LSB 0
`define STATUS_BEAT_LSB 2
`define STATUS_DRIVE_BIT 4
`define STATUS_ORDER_BIT 5
`define CTRL_COUNT_EN_BIT 0
`define CTRL_COUNT_CLR_BIT 1

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define CTRL_COUNT_EN_RESET 1'h1
`define BEATS_RESET 32'h0000_0000
`define READ_ZERO 32'h0000_0000

`endif

// file: sram_bus_pkg.sv
package sram_bus_pkg;

    // ------------------------------------------------------------------------
    // Kind of data transfer pending for the next enabled edge
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        OP_IDLE = 2'h0,
        OP_READ = 2'h1,
        OP_WRITE = 2'h3
    } op_e;

    // ------------------------------------------------------------------------
    // Control pins sampled at every rising edge
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic clk_gate_low;
        logic read_not_write;
        logic advance_or_load;
        logic chip_select_a_low;
        logic chip_select_b_high;
        logic chip_select_c_low;
        logic [3:0] byte_lane_write_low;
    } sram_ctrl_s;

    // ------------------------------------------------------------------------
    // One data beat: lane i is data[8i+7:8i] plus parity_lane[i]
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [3:0] parity_lane;
        logic [31:0] data;
    } sram_word_s;

endpackage

// file: level_sync.sv
`timescale 1ns/1ps

module level_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Level in and filtered level out
    input wire logic din,
    output logic dout
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic out;
    } sync_state_s;

    sync_state_s q;
    sync_state_s next_q;

    always_comb begin
        next_q = q;
        next_q.s1 = din;
        next_q.s2 = q.s1;
        next_q.s3 = q.s2;
        // Accept a change only once the last two stages agree
        if (q.s2 == q.s3) begin
            next_q.out = q.s3;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign dout = q.out;

endmodule // level_sync

// file: burst_step.sv
`timescale 1ns/1ps

module burst_step (
    // Burst start bits, beat index and order
    input wire logic [1:0] start_lo,
    input wire logic [1:0] beat,
    input wire logic interleave,
    // Low address bits of this beat
    output logic [1:0] addr_lo
);

    always_comb begin
        if (interleave) begin
            addr_lo = start_lo ^ beat; // R17
        end else begin
            addr_lo = start_lo + beat; // R07
        end
    end

endmodule // burst_step

// file: sync_sram_core.sv
`timescale 1ns/1ps
`include "sram_bus_map.svh"

// How it works
// R01 - Inputs captured at rising edge; read data driven right after that edge.
// R02 - Selected load read latches the address and drives that word next cycle.
// R03 - Load write takes bus data at next enabled edge, even during deselect.
// R04 - Read data still driven in a following deselect cycle, then bus floats.
// R05 - Advance after read bumps the counter, ignoring address and direction.
// R06 - Advance after write bumps the counter and keeps the write direction.
// R07 - Linear order adds one to the two low bits modulo four, wrapping.
// R08 - A new load may coincide with the last burst beat, no idle cycle.
// R09 - Clock gate high freezes all state and the driven data. Here only the transfer state freezes; APB registers still update.
// R10 - After suspension, write data is taken at next enabled edge.
// R11 - Loads may follow every enabled cycle, reads and writes mixed freely.
// R12 - Load with select false deselects; bus goes high impedance a cycle later.
// R13 - Advance after deselect is a no-operation with bus high impedance.
// R14 - Selection needs both low selects low and the high select high.
// R15 - Data outputs stay high impedance until a read is loaded.
// R16 - Address is 18 bits; a beat has 32 data plus four parity bits.
// R17 - Static order pin picks linear or interleaved (start XOR beat) order.
// R18 - Lane write strobes come with the address or beat, before the data.
// R19 - Each lane strobe enables one byte plus its parity bit.
// R20 - The controller keeps off the bus while expecting read data.
// R21 - Advance with nothing pending starts no access and changes no contents.
module sync_sram_core #(
    parameter int ADDR_W = 18,
    parameter int PADDR_W = 12
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Memory bus from the controller
    input wire logic [ADDR_W-1:0] address,
    input wire sram_bus_pkg::sram_ctrl_s ctrl,
    input wire sram_bus_pkg::sram_word_s data_in,
    // Memory data drive
    output sram_bus_pkg::sram_word_s data_out,
    output logic data_oe,
    // Static burst order strap
    input wire logic burst_order_select
);

    localparam int DEPTH = 1 << ADDR_W;

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    typedef struct packed {
        sram_bus_pkg::op_e op;
        logic [ADDR_W-1:0] addr;
        logic [1:0] start_lo;
        logic [1:0] beat;
        logic [3:0] lane_we_low;
        logic drive;
        sram_bus_pkg::sram_word_s rdata;
        logic count_en;
        logic [31:0] beats;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } dev_state_s;

    dev_state_s q;
    dev_state_s next_q;

    // ------------------------------------------------------------------------
    // What the controller asks of one rising edge
    // ------------------------------------------------------------------------
    // Gray steps along load, burst and stop
    typedef enum logic [2:0] {
        SUSPENDED = 3'h0,
        LOAD_RD = 3'h1,
        LOAD_WR = 3'h3,
        ADVANCE = 3'h2,
        STOP = 3'h6,
        NOOP = 3'h7
    } edge_kind_e;

    sram_bus_pkg::sram_word_s mem [0:DEPTH-1];

    logic interleave;
    logic [1:0] step_beat;
    logic [1:0] step_lo;
    logic enabled;
    logic selected;
    logic mem_we;
    logic [35:0] lane_mask;
    sram_bus_pkg::sram_word_s write_word;
    sram_bus_pkg::sram_word_s store_word;
    edge_kind_e edge_kind;
    sram_bus_pkg::sram_word_s read_raw;
    sram_bus_pkg::sram_word_s read_word;
    logic [31:0] status_word;
    logic [31:0] ctrl_word;
    logic apb_first;
    logic apb_commit;
    logic hit_status;
    logic hit_ctrl;
    logic hit_beats;
    logic ctrl_write;
    logic count_clear;
    logic beat_done;

    // ------------------------------------------------------------------------
    // Strap synchroniser and burst address step
    // ------------------------------------------------------------------------
    // The strap is asynchronous to pclk, so it is filtered before use
    level_sync u_order_sync (
        .clk(pclk),
        .rst_n(presetn),
        .din(burst_order_select),
        .dout(interleave)
    );

    // Beat index of the next data phase; wraps after the fourth beat
    assign step_beat = q.beat + 2'h1;

    burst_step u_step (
        .start_lo(q.start_lo),
        .beat(step_beat),
        .interleave(interleave),
        .addr_lo(step_lo)
    );

    // ------------------------------------------------------------------------
    // Cycle decode
    // ------------------------------------------------------------------------
    assign enabled = !ctrl.clk_gate_low; // R09
    assign selected = !ctrl.chip_select_a_low && ctrl.chip_select_b_high && !ctrl.chip_select_c_low; // R14

    // Pending write lands at the next enabled edge, whatever that edge loads
    assign mem_we = enabled && (q.op == sram_bus_pkg::OP_WRITE); // R03 R10 R06
    assign write_word = data_in; // R01

    // Byte lanes of the pending write merged over the word already stored
    assign store_word = (mem[q.addr] & ~lane_mask) | (write_word & lane_mask); // R19

    // One kind per edge; an advance only counts while a transfer is pending
    always_comb begin
        if (!enabled) begin
            edge_kind = SUSPENDED; // R09
        end else if (ctrl.advance_or_load) begin
            if (q.op != sram_bus_pkg::OP_IDLE) begin
                edge_kind = ADVANCE; // R05 R06
            end else begin
                edge_kind = NOOP; // R13 R21
            end
        end else if (!selected) begin
            edge_kind = STOP; // R12
        end else if (ctrl.read_not_write) begin
            edge_kind = LOAD_RD; // R02
        end else begin
            edge_kind = LOAD_WR; // R03
        end
    end

    always_comb begin
        lane_mask = '0;
        for (int i = 0; i < 4; i++) begin
            if (!q.lane_we_low[i]) begin
                lane_mask[i*8 +: 8] = 8'hFF; // R19
                lane_mask[32 + i] = 1'b1; // R19
            end
        end
    end

    // ------------------------------------------------------------------------
    // Register view
    // ------------------------------------------------------------------------
    // Status mirrors the live transfer state
    always_comb begin
        status_word = `READ_ZERO;
        status_word[`STATUS_OP_LSB +: 2] = q.op;
        status_word[`STATUS_BEAT_LSB +: 2] = q.beat;
        status_word[`STATUS_DRIVE_BIT] = q.drive;
        status_word[`STATUS_ORDER_BIT] = interleave;
        ctrl_word = `READ_ZERO;
        ctrl_word[`CTRL_COUNT_EN_BIT] = q.count_en;
    end

    // Exact word match; unaligned addresses fall to the error path
    assign hit_status = (paddr == `STATUS_OFFSET);
    assign hit_ctrl = (paddr == `CTRL_OFFSET);
    assign hit_beats = (paddr == `BEATS_OFFSET);
    assign apb_first = psel && penable && !q.pready;
    assign apb_commit = psel && penable && q.pready;
    // Writes act only at the edge that sees pready, and only on a mapped word
    assign ctrl_write = apb_commit && pwrite && !q.pslverr && hit_ctrl;
    assign count_clear = ctrl_write && pwdata[`CTRL_COUNT_CLR_BIT];
    assign beat_done = enabled && (q.op != sram_bus_pkg::OP_IDLE);

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb begin
        next_q = q;
        read_raw = '0;
        read_word = '0;

        unique case (edge_kind)
            SUSPENDED: begin
                // Blocked edge: no transfer state moves and driven data stays on the bus
            end
            LOAD_RD: begin
                // New load, back to back with whatever just completed
                next_q.op = sram_bus_pkg::OP_READ; // R02 R08 R11
                next_q.addr = address; // R16
                next_q.start_lo = address[1:0];
                next_q.beat = 2'h0;
                next_q.lane_we_low = ctrl.byte_lane_write_low;
            end
            LOAD_WR: begin
                next_q.op = sram_bus_pkg::OP_WRITE; // R08 R11
                next_q.addr = address; // R16
                next_q.start_lo = address[1:0];
                next_q.beat = 2'h0;
                // Strobes of the first beat come with the address
                next_q.lane_we_low = ctrl.byte_lane_write_low; // R18
            end
            ADVANCE: begin
                // Direction and upper address kept from the load
                next_q.beat = step_beat; // R05 R06 R07
                next_q.addr = {q.addr[ADDR_W-1:2], step_lo}; // R07 R17
                next_q.lane_we_low = ctrl.byte_lane_write_low; // R18
            end
            STOP: begin
                // A transfer still pending completes at this edge
                next_q.op = sram_bus_pkg::OP_IDLE; // R12
            end
            NOOP: begin
                next_q.op = sram_bus_pkg::OP_IDLE; // R13 R21
            end
        endcase

        if (enabled) begin
            read_raw = mem[next_q.addr];
            // Forward the write landing at this same edge
            if (mem_we && (q.addr == next_q.addr)) begin
                read_word = store_word;
            end else begin
                read_word = read_raw;
            end

            // Only a read drives; writes and deselects float a cycle later
            next_q.drive = (next_q.op == sram_bus_pkg::OP_READ); // R04 R12 R13 R15
            if (next_q.op == sram_bus_pkg::OP_READ) begin
                next_q.rdata = read_word; // R02 R05
            end
        end

        // APB: one wait state, effect at the edge where pready is seen high
        next_q.pready = apb_first;
        next_q.pslverr = 1'b0;
        next_q.prdata = `READ_ZERO;
        if (apb_first) begin
            if (hit_status) begin
                next_q.prdata = status_word;
            end else if (hit_ctrl) begin
                next_q.prdata = ctrl_word;
            end else if (hit_beats) begin
                next_q.prdata = q.beats;
            end else begin
                // Unmapped word: error response and no data
                next_q.pslverr = 1'b1;
            end
        end
        if (ctrl_write) begin
            next_q.count_en = pwdata[`CTRL_COUNT_EN_BIT];
        end

        // Clear first, so a beat in the clearing cycle still counts
        if (count_clear) begin
            next_q.beats = `BEATS_RESET;
        end
        if (beat_done && q.count_en) begin
            next_q.beats = next_q.beats + 32'h0000_0001;
        end
    end

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    // Reset touches every register, read data too; the array keeps no reset value
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q.op <= sram_bus_pkg::OP_IDLE;
            q.addr <= '0;
            q.start_lo <= 2'h0;
            q.beat <= 2'h0;
            q.lane_we_low <= 4'hF;
            q.drive <= 1'b0; // R15
            q.rdata <= '0;
            q.count_en <= `CTRL_COUNT_EN_RESET;
            q.beats <= `BEATS_RESET;
            q.pready <= 1'b0;
            q.prdata <= `READ_ZERO;
            q.pslverr <= 1'b0;
        end else begin
            q <= next_q;
        end
    end

    // ------------------------------------------------------------------------
    // Array, byte-lane write
    // ------------------------------------------------------------------------
    always_ff @(posedge pclk) begin
        if (mem_we) begin
            mem[q.addr] <= store_word; // R03 R19
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    // Every output leaves straight from a flop
    assign data_out = q.rdata; // R01
    assign data_oe = q.drive; // R04
    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;

endmodule // sync_sram_core

// file: sram_bus_properties.sv
`timescale 1ns/1ps
module sram_bus_checker (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Register handshake
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    // Memory bus
    input wire sram_bus_pkg::sram_ctrl_s ctrl,
    input wire sram_bus_pkg::sram_word_s data_out,
    input wire logic data_oe
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire en = !ctrl.clk_gate_low;
    wire sel = !ctrl.chip_select_a_low && ctrl.chip_select_b_high && !ctrl.chip_select_c_low;
    wire ld_rd = en && !ctrl.advance_or_load && sel && ctrl.read_not_write;
    wire ld_wr = en && !ctrl.advance_or_load && sel && !ctrl.read_not_write;
    wire desel = en && !ctrl.advance_or_load && !sel;
    wire adv = en && ctrl.advance_or_load;
    chk_load_read_drive: assert property (ld_rd |=> data_oe)
        else $error("read load not driven");
    chk_write_quiet: assert property (ld_wr |=> !data_oe)
        else $error("bus driven after write load");
    chk_deselect_float: assert property (desel |=> !data_oe)
        else $error("bus driven after deselect");
    chk_burst_read: assert property (ld_rd ##1 adv |=> data_oe)
        else $error("burst read beat not driven");
    chk_burst_write: assert property (ld_wr ##1 adv |=> !data_oe)
        else $error("burst write beat drove bus");
    chk_noop_float: assert property (desel ##1 adv |=> !data_oe)
        else $error("noop drove bus");
    chk_suspend_hold: assert property (!en |=> $stable(data_oe) && $stable(data_out))
        else $error("suspended edge changed bus");
    chk_drive_cause: assert property ($rose(data_oe) |-> $past(ld_rd))
        else $error("bus driven without read load");
    chk_ready_pulse: assert property (psel && penable && !pready |=> pready ##1 !pready)
        else $error("ready not a single pulse");
endmodule // sram_bus_checker

bind sync_sram_core sram_bus_checker sram_bus_checker_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pready(pready), .ctrl(ctrl), .data_out(data_out), .data_oe(data_oe));

// file: sram_ctrl_model.sv
`timescale 1ns/1ps
module sram_ctrl_model (
    // Clock
    input wire logic pclk,
    // Toward the device
    output logic [5:0] address,
    output sram_bus_pkg::sram_ctrl_s ctrl,
    output sram_bus_pkg::sram_word_s data_in,
    // Device drive and resolved bus
    input wire sram_bus_pkg::sram_word_s data_out,
    input wire logic data_oe,
    output sram_bus_pkg::sram_word_s bus
);
    assign bus = data_oe ? data_out : data_in;
    initial begin
        ctrl = '1;
        address = '0;
        data_in = '0;
    end
    // Kinds: 0 load read, 1 load write, 2 advance, 3 deselect, 4 suspend
    task step(input logic [2:0] k, input logic [5:0] a, input logic [3:0] bw, input logic [35:0] wd,
              output logic oe, output logic [35:0] q);
        @(posedge pclk);
        ctrl.clk_gate_low <= k == 3'h4;
        ctrl.advance_or_load <= k == 3'h2 || (k == 3'h4 && a[1]);
        ctrl.read_not_write <= k == 3'h0 || (k > 3'h1 && a[0]);
        ctrl.chip_select_a_low <= k == 3'h3 && bw[1:0] == 2'h1;
        ctrl.chip_select_b_high <= !(k == 3'h3 && bw[1:0] == 2'h2);
        ctrl.chip_select_c_low <= k == 3'h3 && (bw[1:0] == 2'h0 || bw[1:0] == 2'h3);
        ctrl.byte_lane_write_low <= bw;
        address <= a;
        data_in <= wd;
        // Settled half a period on: the answer to the edge just passed
        @(negedge pclk);
        oe = data_oe;
        q = bus;
    endtask
endmodule // sram_ctrl_model

// file: flow_through_sync_sram_bus_ops_tb_top.sv
`timescale 1ns/1ps
module flow_through_sync_sram_bus_ops_tb_top;
    logic pclk = 0;
    logic presetn = 0;
    logic psel = 0, penable = 0, pwrite = 0, pready, pslverr, data_oe, e, ord = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, r, nb = 0, rs = 32'hD58D4B9A;
    logic [5:0] address, pa = 0;
    logic [1:0] pend = 0, pk = 0;
    logic [3:0] pbw = 0;
    logic [35:0] mem [64];
    sram_bus_pkg::sram_ctrl_s ctrl;
    sram_bus_pkg::sram_word_s data_in, data_out, bus;
    int n_errors = 0, samples_checked = 0;
    always #50 pclk = ~pclk;
    sync_sram_core #(.ADDR_W(6)) sync_sram_core_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .address(address), .ctrl(ctrl), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe), .burst_order_select(ord));
    sram_ctrl_model sram_ctrl_model_i (.pclk(pclk), .address(address), .ctrl(ctrl), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe), .bus(bus));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [5:0] cur();
        return {pa[5:2], ord ? pa[1:0] ^ pk : pa[1:0] + pk};
    endfunction
    function automatic logic [35:0] merge(input logic [35:0] o, n, input logic [3:0] bw);
        merge = o;
        for (int i = 0; i < 4; i++) if (!bw[i]) begin
            merge[8*i+:8] = n[8*i+:8];
            merge[32+i] = n[32+i];
        end
    endfunction
    task chk(input string nm, input logic [35:0] s, x);
        samples_checked++;
        if (s !== x) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, x, s);
        end
    endtask
    task give_verdict;
        if (n_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task op(input logic [2:0] k, input logic [5:0] a, input logic [3:0] bw);
        logic oe;
        logic [35:0] q, wd;
        rs = lfsr(rs);
        wd = {rs[7:4], rs};
        sram_ctrl_model_i.step(k, a, bw, wd, oe, q);
        chk("data_oe", 36'(oe), 36'(pend == 2'h1));
        if (pend == 2'h1) chk("rdata", q, mem[cur()]);
        if (k != 3'h4) begin
            if (pend != 2'h0) nb++;
            if (pend == 2'h3) mem[cur()] = merge(mem[cur()], wd, pbw);
            if (k < 3'h2) begin
                pend = k[0] ? 2'h3 : 2'h1;
                pa = a;
                pk = 2'h0;
                pbw = bw;
            end else if (k == 3'h3) pend = 2'h0;
            else if (pend != 2'h0) begin
                pk++;
                pbw = bw;
            end
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        for (n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            n_errors++;
            give_verdict;
        end
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        give_verdict;
    end
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1;
        apb(0, 12'h004, 0);
        chk("ctrl", 36'(r[1:0]), 36'h1);
        apb(0, 12'h00C, 0);
        chk("unmapped", 36'({e, r}), {3'h0, 1'b1, 32'h0});
        apb(1, 12'h004, 32'h3);
        nb = 0;
        for (int i = 0; i < 64; i++) op(i[1:0] == 2'h0 ? 3'h1 : 3'h2, i[5:0], 4'h0);
        op(0, 6'h05, 0);
        repeat (6) op(2, rs[5:0], 0);
        op(3, 0, 0);
        repeat (2) op(2, 0, 0);
        op(1, 6'h09, 4'h5);
        repeat (2) op(4, 6'h3F, 0);
        op(0, 6'h09, 0);
        op(2, 0, 4'hA);
        op(4, 0, 0);
        apb(0, 12'h000, 0);
        chk("status", 36'(r[5:0]), 36'({ord, 1'b1, pk, 2'h1}));
        apb(0, 12'h008, 0);
        chk("beats", 36'(r), 36'(nb));
        for (int p = 0; p < 2; p++) begin
            repeat (2) op(3, 0, 0);
            @(posedge pclk) ord <= !p[0];
            repeat (8) op(3, 0, 0);
            repeat (300) begin
                rs = lfsr(rs);
                op(3'(rs[2:0] % 5), rs[13:8], rs[19:16] & {4{rs[20]}});
            end
        end
        give_verdict;
    end
endmodule // flow_through_sync_sram_bus_ops_tb_top
